//--- verilog/rlv_defs.svh
/*
 * offsets, field positions, reset values and timing counts of the
 * wakeup timer and undervoltage control bank.
 * assumes inclusion by bare name; definitions only.
 */
`ifndef RLV_DEFS_SVH
`define RLV_DEFS_SVH

// register byte offsets on apb
`define RLV_OFF_WAKE        12'h000
`define RLV_OFF_UVLT        12'h004
`define RLV_OFF_IRQ_STATUS  12'h008
`define RLV_OFF_IRQ_MASK    12'h00c

// wakeup control fields
`define RLV_WK_FLAG_BIT     7
`define RLV_WK_ACK_BIT      6
`define RLV_WK_CLKS_BIT     5
`define RLV_WK_IE_BIT       4
`define RLV_WK_RESET        8'h00

// undervoltage control fields
`define RLV_UV_FLAG_BIT     7
`define RLV_UV_ACK_BIT      6
`define RLV_UV_IE_BIT       5
`define RLV_UV_RE_BIT       4
`define RLV_UV_SE_BIT       3
`define RLV_UV_DE_BIT       2
`define RLV_UV_RESET        8'h1c

// interrupt status bits
`define RLV_IRQ_WAKE_BIT    0
`define RLV_IRQ_UVLT_BIT    1

// internal base tick: 1.15 ms at 50 MHz, 20 ns clock period
`define RLV_TRTI_NS         1150000
`define RLV_CLK_NS          20
`define RLV_TRTI_CYCLES     (`RLV_TRTI_NS / `RLV_CLK_NS)
// base period count for code 000 is 8 ticks (9.2 ms)
`define RLV_INT_BASE_TICKS  8

`endif

//--- verilog/rlv_pkg.sv
/*
 * types shared by the wakeup and undervoltage control bank.
 * assumes rlv_defs.svh is on the include path.
 */
package rlv_pkg;
    typedef logic [7:0]  rlv_byte_t;
    typedef logic [15:0] rlv_count_t;
    typedef logic [2:0]  rlv_period_t;
endpackage

//--- verilog/rlv_if.sv
/*
 * interface between the register bank and its wakeup divider.
 * assumes one clock domain, pclk.
 */
`timescale 1ns/1ps
interface rlv_if;
    logic              clk_sel;
    rlv_pkg::rlv_period_t period;
    logic              ext_tick;
    logic              timeout;
    modport bank (output clk_sel, output period, output ext_tick, input timeout);
    modport timer (input clk_sel, input period, input ext_tick, output timeout);
endinterface

//--- verilog/rlv_wake_timer.sv
/*
 * periodic wakeup divider: counts internal base ticks or synchronised
 * external clock edges and pulses timeout once per period.
 * assumes ext_tick is already a one-cycle pulse on pclk.
 */
`timescale 1ns/1ps
`include "rlv_defs.svh"
module rlv_wake_timer (
    input wire logic pclk,
    input wire logic presetn,
    rlv_if.timer     tif
);
    import rlv_pkg::*;

    typedef struct packed {
        logic [16:0] pre;
        logic [15:0] cnt;
        logic        timeout;
        logic [3:0]  cfg;
    } rlv_tmr_s;

    localparam logic [16:0] PRE_LAST = 17'(`RLV_TRTI_CYCLES - 1);

    rlv_tmr_s st;
    rlv_tmr_s next_st;
    logic     tick;
    logic [15:0] limit;

    // terminal count per code, counted in ticks
    always_comb begin
        limit = 16'h0000;
        if (!tif.clk_sel) begin
            limit = 16'(`RLV_INT_BASE_TICKS << tif.period) - 16'h0001;
        end else begin
            unique case (tif.period)
                3'h1:    limit = 16'h00ff;
                3'h2:    limit = 16'h03ff;
                3'h3:    limit = 16'h07ff;
                3'h4:    limit = 16'h0fff;
                3'h5:    limit = 16'h1fff;
                3'h6:    limit = 16'h3fff;
                3'h7:    limit = 16'h7fff;
                default: limit = 16'h0000;
            endcase
        end
    end

    // prescaler, period counter; a config change restarts the period
    always_comb begin
        next_st = st;
        next_st.timeout = 1'b0;
        next_st.cfg = {tif.clk_sel, tif.period};
        tick = 1'b0;
        if (!tif.clk_sel) begin
            if (st.pre == PRE_LAST) begin
                next_st.pre = 17'h00000;
                tick = 1'b1;
            end else begin
                next_st.pre = st.pre + 17'h00001;
            end
        end else begin
            next_st.pre = 17'h00000;
            tick = tif.ext_tick;
        end
        if (st.cfg != {tif.clk_sel, tif.period}) begin
            next_st.cnt = 16'h0000;
            next_st.pre = 17'h00000;
        end else if (tif.clk_sel && tif.period == 3'h0) begin
            next_st.cnt = 16'h0000; // stopped, no timeouts
        end else if (tick) begin
            if (st.cnt == limit) begin
                next_st.cnt = 16'h0000; // restart each period
                next_st.timeout = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tif.timeout = st.timeout;

    a_ext_stop: assert property (@(posedge pclk) disable iff (!presetn)
        (tif.clk_sel && tif.period == 3'h0) |=> !tif.timeout)
        else $error("timeout while external timer stopped");
    a_ext_256: assert property (@(posedge pclk) disable iff (!presetn)
        (st.cnt == 16'h00ff && tif.clk_sel && tif.period == 3'h1 && tif.ext_tick
         && st.cfg == {tif.clk_sel, tif.period}) |=> tif.timeout && st.cnt == 16'h0000)
        else $error("external 256 period wrong");
    a_int_base: assert property (@(posedge pclk) disable iff (!presetn)
        (!tif.clk_sel && tif.period == 3'h0) |-> limit == 16'h0007)
        else $error("internal base period wrong");
    a_restart_cnt: assert property (@(posedge pclk) disable iff (!presetn)
        tif.timeout |-> st.cnt == 16'h0000)
        else $error("counter not restarted");
endmodule

//--- verilog/rlv_bank.sv
/*
 * wakeup timer and undervoltage status/control bank on apb.
 * assumes ext_clk and undervoltage come from pins and are
 * asynchronous; stop_mode is from logic on pclk.
 */
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "rlv_defs.svh"
module rlv_bank (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    input  wire logic [3:0]   pstrb,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic         ext_clk,
    input  wire logic         undervoltage,
    input  wire logic         stop_mode,
    output logic              wakeup_irq,
    output logic              undervoltage_irq,
    output logic              undervoltage_reset,
    output logic              irq
);
    import rlv_pkg::*;

    // notes for the next owner:
    // - pready is tied high; every access ends in one access cycle
    // - only byte lane 0 carries register bits, other lanes are ignored
    // - ext_clk must stay below pclk/4, else edges are lost in the sync
    // - undervoltage is a level; the flag re-sets while the input stays
    //   high, so an ack only sticks once the input has fallen
    // - the write-once lock follows any first write, whatever its value,
    //   so boot code should write the wanted value even if it is reset
    // - stop_mode is taken as a same-clock level, not synchronised
    // - an event in the same cycle as its clear wins, the flag stays set
    // - the undervoltage flag is forced clear while detect enable is off
    // - the summary irq is separate from the two per-source requests
    // - unmapped offsets answer with pslverr and read as zero
    // - internal periods are long; the divider restarts on any change
    //   of clock select or period, so a rewrite of the same value is free

    // state of the bank, except the wakeup divider, in one word
    // ext_sync/uv_sync: two-stage synchronisers for the pin inputs
    // ext_prev: last synchronised level, for the rising-edge detect
    // wakeup_*: fields of the wakeup control register
    // undervoltage_*: fields of the undervoltage control register
    // once_done: set by the first undervoltage write, locks bits 4..2
    // irq_status/irq_mask: summary interrupt, sticky and masked
    // rdata/slverr: read data and error taken in the setup cycle
    typedef struct packed {
        logic [1:0]  ext_sync;
        logic        ext_prev;
        logic [1:0]  uv_sync;
        logic        wakeup_timeout_flag;
        logic        wakeup_clock_select;
        logic        wakeup_interrupt_enable;
        rlv_period_t wakeup_period_select;
        logic        undervoltage_flag;
        logic        undervoltage_interrupt_enable;
        logic        undervoltage_reset_enable;
        logic        undervoltage_stop_enable;
        logic        undervoltage_detect_enable;
        logic        once_done;
        logic [1:0]  irq_status;
        logic [1:0]  irq_mask;
        logic [31:0] rdata;
        logic        slverr;
    } rlv_bank_s;

    // reset image of the undervoltage register, split per bit below
    localparam rlv_byte_t UV_RST = `RLV_UV_RESET;

    rlv_bank_s st;
    rlv_bank_s next_st;
    rlv_if     tif ();

    logic      wr_en;
    logic      rd_en;
    logic      hit;
    logic      uv_active;
    logic      uv_event;
    rlv_byte_t wake_rd;
    rlv_byte_t uvlt_rd;

    rlv_wake_timer u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .tif     (tif)
    );

    // timer sees registered config and a synchronised rising edge
    assign tif.clk_sel  = st.wakeup_clock_select;
    assign tif.period   = st.wakeup_period_select;
    assign tif.ext_tick = st.ext_sync[1] & ~st.ext_prev;

    // zero wait state slave, access phase completes at once
    // read data are taken in the setup cycle so prdata is settled
    // through the access cycle, at the edge where the master samples it
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;
    assign hit   = (paddr == `RLV_OFF_WAKE) || (paddr == `RLV_OFF_UVLT) ||
                   (paddr == `RLV_OFF_IRQ_STATUS) || (paddr == `RLV_OFF_IRQ_MASK);

    // detection off in stop unless stop enable kept it alive;
    // stop_mode is same-clock logic, so it is used without a sync
    assign uv_active = st.undervoltage_detect_enable &
                       (~stop_mode | st.undervoltage_stop_enable);
    assign uv_event  = uv_active & st.uv_sync[1];

    // ack bits read zero, unimplemented bits read zero
    assign wake_rd = {st.wakeup_timeout_flag, 1'b0, st.wakeup_clock_select,
                      st.wakeup_interrupt_enable, 1'b0,
                      st.wakeup_period_select};
    assign uvlt_rd = {st.undervoltage_flag, 1'b0, st.undervoltage_interrupt_enable,
                      st.undervoltage_reset_enable, st.undervoltage_stop_enable,
                      st.undervoltage_detect_enable, 2'b00};

    // register, flag and read-path next state
    always_comb begin
        next_st = st;
        next_st.ext_sync = {st.ext_sync[0], ext_clk};
        next_st.ext_prev = st.ext_sync[1];
        next_st.uv_sync  = {st.uv_sync[0], undervoltage};
        next_st.slverr   = 1'b0;
        // writes land at the access edge; only byte lane 0 holds bits,
        // so a write with pstrb[0] low changes nothing at all
        if (wr_en && pstrb[0]) begin
            if (paddr == `RLV_OFF_WAKE) begin
                if (pwdata[`RLV_WK_ACK_BIT]) begin
                    next_st.wakeup_timeout_flag = 1'b0;
                end
                next_st.wakeup_clock_select     = pwdata[`RLV_WK_CLKS_BIT];
                next_st.wakeup_interrupt_enable = pwdata[`RLV_WK_IE_BIT];
                next_st.wakeup_period_select    = pwdata[2:0];
            end
            if (paddr == `RLV_OFF_UVLT) begin
                if (pwdata[`RLV_UV_ACK_BIT]) begin
                    next_st.undervoltage_flag = 1'b0;
                end
                next_st.undervoltage_interrupt_enable = pwdata[`RLV_UV_IE_BIT];
                if (!st.once_done) begin
                    next_st.undervoltage_reset_enable  = pwdata[`RLV_UV_RE_BIT];
                    next_st.undervoltage_stop_enable   = pwdata[`RLV_UV_SE_BIT];
                    next_st.undervoltage_detect_enable = pwdata[`RLV_UV_DE_BIT];
                    next_st.once_done = 1'b1;
                end
            end
            if (paddr == `RLV_OFF_IRQ_STATUS) begin
                next_st.irq_status = st.irq_status & ~pwdata[1:0];
            end
            if (paddr == `RLV_OFF_IRQ_MASK) begin
                next_st.irq_mask = pwdata[1:0];
            end
        end
        // events set after clears so a same-cycle set wins
        if (tif.timeout) begin
            next_st.wakeup_timeout_flag = 1'b1;
            next_st.irq_status[`RLV_IRQ_WAKE_BIT] = 1'b1;
        end
        if (uv_event) begin
            next_st.undervoltage_flag = 1'b1;
            next_st.irq_status[`RLV_IRQ_UVLT_BIT] = 1'b1;
        end
        if (!st.undervoltage_detect_enable) begin
            next_st.undervoltage_flag = 1'b0;
        end
        // read data captured in setup, held through access;
        // a write setup leaves the last read data standing
        if (rd_en) begin
            unique case (paddr)
                `RLV_OFF_WAKE:       next_st.rdata = {24'h000000, wake_rd};
                `RLV_OFF_UVLT:       next_st.rdata = {24'h000000, uvlt_rd};
                `RLV_OFF_IRQ_STATUS: next_st.rdata = {30'h00000000, st.irq_status};
                `RLV_OFF_IRQ_MASK:   next_st.rdata = {30'h00000000, st.irq_mask};
                default:             next_st.rdata = 32'h00000000;
            endcase
        end
        if (psel && !penable && !hit) begin
            next_st.slverr = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.undervoltage_reset_enable  <= UV_RST[`RLV_UV_RE_BIT];
            st.undervoltage_stop_enable   <= UV_RST[`RLV_UV_SE_BIT];
            st.undervoltage_detect_enable <= UV_RST[`RLV_UV_DE_BIT];
        end else begin
            st <= next_st;
        end
    end

    assign prdata  = st.rdata;
    assign pready  = 1'b1;
    assign pslverr = st.slverr & psel & penable;

    // request and reset outputs
    // all four requests are levels straight from flops and enables;
    // each drops when its flag is cleared (ack bit for the per-source requests, status w1c for irq)
    // or when its enable or mask bit is cleared
    // the reset request is not registered again: whoever resets the
    // device must also reset this bank, or the request would hold
    assign wakeup_irq = st.wakeup_timeout_flag & st.wakeup_interrupt_enable;
    assign undervoltage_irq = st.undervoltage_flag &
                              st.undervoltage_interrupt_enable;
    assign undervoltage_reset = st.undervoltage_flag & st.undervoltage_reset_enable &
                                st.undervoltage_detect_enable;
    assign irq = |(st.irq_status & st.irq_mask);

    a_wake_set: assert property (@(posedge pclk) disable iff (!presetn)
        tif.timeout |=> st.wakeup_timeout_flag)
        else $error("timeout did not set flag");
    a_wake_ack: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && pstrb[0] && paddr == `RLV_OFF_WAKE && pwdata[6] && !tif.timeout)
        |=> !st.wakeup_timeout_flag)
        else $error("ack did not clear flag");
    a_wake_rd_zero: assert property (@(posedge pclk) disable iff (!presetn)
        wake_rd[6] == 1'b0 && wake_rd[3] == 1'b0 && prdata[31:8] == 24'h000000)
        else $error("unimplemented bits nonzero");
    a_wake_irq: assert property (@(posedge pclk) disable iff (!presetn)
        wakeup_irq == (st.wakeup_timeout_flag && st.wakeup_interrupt_enable))
        else $error("wakeup irq gating wrong");
    a_uv_set: assert property (@(posedge pclk) disable iff (!presetn)
        (uv_event && st.undervoltage_detect_enable) |=> st.undervoltage_flag)
        else $error("undervoltage not flagged");
    a_uv_ack: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && pstrb[0] && paddr == `RLV_OFF_UVLT && pwdata[6] && !uv_event)
        |=> !st.undervoltage_flag)
        else $error("undervoltage ack failed");
    a_uv_irq: assert property (@(posedge pclk) disable iff (!presetn)
        (st.undervoltage_flag && st.undervoltage_interrupt_enable) |-> undervoltage_irq)
        else $error("undervoltage irq missing");
    a_uv_reset: assert property (@(posedge pclk) disable iff (!presetn)
        undervoltage_reset |-> (st.undervoltage_reset_enable && st.undervoltage_detect_enable))
        else $error("reset without enable");
    a_uv_stop: assert property (@(posedge pclk) disable iff (!presetn)
        (stop_mode && !st.undervoltage_stop_enable) |-> !uv_event)
        else $error("detection alive in stop");
    a_uv_master: assert property (@(posedge pclk) disable iff (!presetn)
        !st.undervoltage_detect_enable |=> !st.undervoltage_flag)
        else $error("flag while disabled");
    a_write_once: assert property (@(posedge pclk) disable iff (!presetn)
        st.once_done |=> $stable(st.undervoltage_detect_enable) &&
                         $stable(st.undervoltage_reset_enable))
        else $error("write-once bit changed");

    // further checks on flags, fields, requests, read path, error response and lock
    a_wake_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (st.wakeup_timeout_flag && !(wr_en && pstrb[0] && paddr == `RLV_OFF_WAKE
         && pwdata[`RLV_WK_ACK_BIT])) |=> st.wakeup_timeout_flag)
        else $error("wakeup flag lost without ack");

    a_wake_rd_ack: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_en && paddr == `RLV_OFF_WAKE) |=> prdata[`RLV_WK_ACK_BIT] == 1'b0)
        else $error("wakeup ack bit read back");

    a_clk_sel_wr: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && pstrb[0] && paddr == `RLV_OFF_WAKE)
        |=> tif.clk_sel == $past(pwdata[`RLV_WK_CLKS_BIT]))
        else $error("clock select not written");

    a_wake_irq_off: assert property (@(posedge pclk) disable iff (!presetn)
        !st.wakeup_interrupt_enable |-> !wakeup_irq)
        else $error("wakeup irq while disabled");

    a_period_wr: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && pstrb[0] && paddr == `RLV_OFF_WAKE)
        |=> tif.period == $past(pwdata[2:0]))
        else $error("period select not written");

    a_wake_rd_hole: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_en && paddr == `RLV_OFF_WAKE) |=> prdata[3] == 1'b0)
        else $error("wakeup hole bit read back");

    a_uv_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (st.undervoltage_flag && st.undervoltage_detect_enable && !(wr_en && pstrb[0]
         && paddr == `RLV_OFF_UVLT && pwdata[`RLV_UV_ACK_BIT])) |=> st.undervoltage_flag)
        else $error("undervoltage flag lost without ack");

    a_uv_rd_ack: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_en && paddr == `RLV_OFF_UVLT)
        |=> prdata[`RLV_UV_ACK_BIT] == 1'b0 && prdata[1:0] == 2'b00)
        else $error("undervoltage ack bit read back");

    a_uv_irq_off: assert property (@(posedge pclk) disable iff (!presetn)
        !st.undervoltage_interrupt_enable |-> !undervoltage_irq)
        else $error("undervoltage irq while disabled");

    a_uv_reset_on: assert property (@(posedge pclk) disable iff (!presetn)
        (st.undervoltage_flag && st.undervoltage_reset_enable
         && st.undervoltage_detect_enable) |-> undervoltage_reset)
        else $error("undervoltage reset missing");

    a_uv_off_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !st.undervoltage_detect_enable |-> !uv_event && !undervoltage_reset)
        else $error("detect logic active while off");

    a_lock_stop: assert property (@(posedge pclk) disable iff (!presetn)
        st.once_done |=> $stable(st.undervoltage_stop_enable))
        else $error("locked stop enable changed");

    a_lock_set: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && pstrb[0] && paddr == `RLV_OFF_UVLT) |=> st.once_done)
        else $error("first write did not lock");

    a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !hit) |-> pslverr)
        else $error("no error on unmapped access");
endmodule

//--- test/tb_rlv_bank.sv
/*
 * self-checking bench for the wakeup timer and undervoltage bank.
 * assumes rlv_defs.svh on the include path; internal periods are
 * too long to run here, so the timer is timed with the external clock.
 */
`timescale 1ns/1ps
`include "rlv_defs.svh"
module tb_rlv_bank;
    import rlv_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_clk;
    logic        undervoltage;
    logic        stop_mode;
    logic        wakeup_irq;
    logic        undervoltage_irq;
    logic        undervoltage_reset;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    int          error_cnt;
    int          tests_run;
    int          cyc;

    rlv_bank i_rlv_bank (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_clk(ext_clk), .undervoltage(undervoltage),
        .stop_mode(stop_mode), .wakeup_irq(wakeup_irq), .undervoltage_irq(undervoltage_irq),
        .undervoltage_reset(undervoltage_reset), .irq(irq));

    // 50 mhz bus clock
    always #10 pclk = ~pclk;

    task automatic give_verdict();
        if (error_cnt == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // hang guard, the run needs roughly 34k cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            error_cnt = error_cnt + 1;
            give_verdict();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_pin(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    // one apb transfer; entered and left just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                       input logic [3:0] st);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 4'h1);
    endtask

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00, 4'h0);
        chk(what, {24'h0, exp}, rd);
        chk_pin({what, " err"}, 1'b0, err);
    endtask

    // ext_clk well below pclk/4: 8 bus cycles per period
    task automatic ext_edges(input int n);
        repeat (n) begin
            repeat (4) @(posedge pclk);
            ext_clk <= 1'b1;
            repeat (4) @(posedge pclk);
            ext_clk <= 1'b0;
        end
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    task automatic t_reset_map();
        rd_chk("wake", `RLV_OFF_WAKE, 8'h00);
        rd_chk("uvlt", `RLV_OFF_UVLT, 8'h1c);
        rd_chk("stat", `RLV_OFF_IRQ_STATUS, 8'h00);
        rd_chk("mask", `RLV_OFF_IRQ_MASK, 8'h00);
        apb(1'b0, 12'h010, 8'h00, 4'h0);
        chk("unmapped", 32'h0, rd);
        chk_pin("unmapped err", 1'b1, err);
    endtask

    task automatic t_wake_fields();
        wr(`RLV_OFF_WAKE, 8'hff);
        rd_chk("wake", `RLV_OFF_WAKE, 8'h37);
        apb(1'b1, `RLV_OFF_WAKE, 8'h00, 4'h0);
        rd_chk("wake", `RLV_OFF_WAKE, 8'h37);
        wr(`RLV_OFF_WAKE, 8'h00);
        rd_chk("wake", `RLV_OFF_WAKE, 8'h00);
    endtask

    // external periods for codes 1..3, then periodic restart and masking
    task automatic t_ext_timer();
        int n [3] = '{256, 1024, 2048};
        for (int c = 1; c <= 3; c++) begin
            wr(`RLV_OFF_WAKE, 8'h70 | c[7:0]);
            ext_edges(n[c-1] - 4);
            rd_chk("wake", `RLV_OFF_WAKE, 8'h30 | c[7:0]);
            ext_edges(8);
            rd_chk("wake", `RLV_OFF_WAKE, 8'hb0 | c[7:0]);
            chk_pin("wakeup_irq", 1'b1, wakeup_irq);
        end
        wr(`RLV_OFF_WAKE, 8'h71);
        ext_edges(260);
        rd_chk("stat", `RLV_OFF_IRQ_STATUS, 8'h01);
        chk_pin("irq", 1'b0, irq);
        wr(`RLV_OFF_IRQ_MASK, 8'h01);
        chk_pin("irq", 1'b1, irq);
        wr(`RLV_OFF_IRQ_STATUS, 8'h01);
        chk_pin("irq", 1'b0, irq);
        wr(`RLV_OFF_WAKE, 8'h31);
        rd_chk("wake", `RLV_OFF_WAKE, 8'hb1);
        wr(`RLV_OFF_WAKE, 8'h71);
        rd_chk("wake", `RLV_OFF_WAKE, 8'h31);
        chk_pin("wakeup_irq", 1'b0, wakeup_irq);
        // same clksel and period, so the count keeps running
        ext_edges(248);
        rd_chk("wake", `RLV_OFF_WAKE, 8'h31);
        ext_edges(8);
        rd_chk("wake", `RLV_OFF_WAKE, 8'hb1);
        wr(`RLV_OFF_WAKE, 8'h21);
        chk_pin("wakeup_irq", 1'b0, wakeup_irq);
        wr(`RLV_OFF_WAKE, 8'h60);
        ext_edges(300);
        rd_chk("wake", `RLV_OFF_WAKE, 8'h20);
    endtask

    task automatic t_uv_main();
        undervoltage <= 1'b1;
        repeat (6) @(posedge pclk);
        rd_chk("uvlt", `RLV_OFF_UVLT, 8'h9c);
        chk_pin("uv_reset", 1'b1, undervoltage_reset);
        chk_pin("uv_irq", 1'b0, undervoltage_irq);
        rd_chk("stat", `RLV_OFF_IRQ_STATUS, 8'h02);
        undervoltage <= 1'b0;
        repeat (6) @(posedge pclk);
        wr(`RLV_OFF_UVLT, 8'h6c);
        rd_chk("uvlt", `RLV_OFF_UVLT, 8'h2c);
        chk_pin("uv_reset", 1'b0, undervoltage_reset);
        wr(`RLV_OFF_UVLT, 8'h10);
        rd_chk("uvlt", `RLV_OFF_UVLT, 8'h0c);
        undervoltage <= 1'b1;
        repeat (6) @(posedge pclk);
        rd_chk("uvlt", `RLV_OFF_UVLT, 8'h8c);
        chk_pin("uv_reset", 1'b0, undervoltage_reset);
        chk_pin("uv_irq", 1'b0, undervoltage_irq);
        wr(`RLV_OFF_UVLT, 8'h20);
        chk_pin("uv_irq", 1'b1, undervoltage_irq);
        undervoltage <= 1'b0;
        repeat (6) @(posedge pclk);
        wr(`RLV_OFF_UVLT, 8'h60);
        rd_chk("uvlt", `RLV_OFF_UVLT, 8'h2c);
        chk_pin("uv_irq", 1'b0, undervoltage_irq);
        stop_mode <= 1'b1;
        undervoltage <= 1'b1;
        repeat (6) @(posedge pclk);
        rd_chk("uvlt", `RLV_OFF_UVLT, 8'hac);
        stop_mode <= 1'b0;
        undervoltage <= 1'b0;
    endtask

    task automatic t_uv_locked(input logic [7:0] v, input logic stop);
        do_reset();
        wr(`RLV_OFF_UVLT, v);
        stop_mode <= stop;
        undervoltage <= 1'b1;
        repeat (6) @(posedge pclk);
        rd_chk("uvlt", `RLV_OFF_UVLT, v);
        chk_pin("uv_reset", 1'b0, undervoltage_reset);
        stop_mode <= 1'b0;
        repeat (6) @(posedge pclk);
        rd_chk("uvlt", `RLV_OFF_UVLT, v | {v[2], 7'h0});
        undervoltage <= 1'b0;
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, ext_clk, undervoltage, stop_mode} = '0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
        error_cnt = 0;
        tests_run = 0;
        cyc = 0;
        do_reset();
        t_reset_map();
        t_wake_fields();
        t_ext_timer();
        do_reset();
        t_uv_main();
        t_uv_locked(8'h00, 1'b0);
        t_uv_locked(8'h04, 1'b1);
        give_verdict();
    end
endmodule
